//--- design/apd_defs.svh
`ifndef APD_DEFS_SVH
`define APD_DEFS_SVH

// Clock rate in kHz (20 MHz)
`define APD_CLK_KHZ          20000
// Inactivity time before auto powerdown, seconds
`define APD_IDLE_S           30
// Idle count: 30 s at 20 MHz
`define APD_IDLE_CYC         (`APD_IDLE_S * `APD_CLK_KHZ * 1000)
// Invalid-level persistence time, microseconds
`define APD_INVALID_US       30
// Invalid count, rounded down, plus one extra cycle for "more than"
`define APD_INVALID_CYC      ((`APD_INVALID_US * `APD_CLK_KHZ) / 1000 + 1)
// Valid-level report delay, microseconds
`define APD_VALID_US         1
// Valid delay count
`define APD_VALID_CYC        ((`APD_VALID_US * `APD_CLK_KHZ) / 1000)
// Wake to ready-to-transmit limit, microseconds
`define APD_WAKE_US          100
// Wake limit count, rounded down
`define APD_WAKE_CYC         ((`APD_WAKE_US * `APD_CLK_KHZ) / 1000)

`endif

//--- design/apd_pkg.sv
package apd_pkg;
    // Power state of the transceiver core
    typedef enum logic [1:0] {
        PWR_DOWN   = 2'b00,
        PWR_WAKING = 2'b01,
        PWR_ACTIVE = 2'b10
    } pwr_state_t;
endpackage

//--- design/apd_edge_det.sv
// Edge detector on a vector of synchronous inputs
module apd_edge_det #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] sig,
    output logic                  any_edge
);
    logic [WIDTH-1:0] prev_r;   // Last sampled value

    // Keep the previous sample
    always_ff @(posedge clk) begin
        if (reset) begin
            // Take the pin level, not zero: a pin idling high
            // would otherwise look like an edge after reset
            prev_r <= sig;
        end else begin
            prev_r <= sig;
        end
    end

    // Any bit changed, either direction
    always_comb begin
        any_edge = |(prev_r ^ sig);
    end
endmodule // apd_edge_det

//--- design/auto_powerdown_control.sv
// Functional notes
// [RQ1] Force-sleep low always powers down
// [RQ2] Force-awake high disables automatic powerdown
// [RQ3] Auto mode only: awake low, sleep high
// [RQ4] 30 s without edges shuts pump
// [RQ5] Any input edge wakes from auto powerdown
// [RQ6] Timer stays expired while powered down
// [RQ7] Manual exit needs both high or edge
// [RQ8] Awake falling edge restarts 30 s hold
// [RQ9] Ready to transmit within 100 us
// [RQ10] Monitor variant disables receiver outputs down
// [RQ11] Flag low after 30 us invalid
// [RQ12] Flag high 1 us after valid
// [RQ13] Flag works in every mode, no effect
// [RQ14] Ready low on powerdown, high at pump
// [RQ15] System may tie flag to both pins
// [RQ16] Hybrid: stays down until valid plus edge
// [RQ17] System may tie both pins together
// [RQ18] Timers are parameterised clock counters
// [RQ19] Synchronous inputs, edges on synced signals
`include "apd_defs.svh"

module auto_powerdown_control #(
    parameter int N_TX         = 2,
    parameter int N_RX         = 2,
    parameter bit HAS_MONITOR  = 1'b0,
    parameter int IDLE_CYC     = `APD_IDLE_CYC,
    parameter int INVALID_CYC  = `APD_INVALID_CYC,
    parameter int VALID_CYC    = `APD_VALID_CYC
) (
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire logic            force_awake_input,
    input  wire logic            force_sleep_input,
    input  wire logic [N_TX-1:0] tx_in,
    input  wire logic [N_RX-1:0] rx_in,
    input  wire logic [N_RX-1:0] rx_level_valid,
    input  wire logic            pump_ok,
    output logic                 pump_en,
    output logic                 tx_en,
    output logic                 rx_out_en,
    output logic                 ready,
    output logic                 level_valid_n_flag
);

    localparam int NE = N_TX + N_RX;
    localparam int WK = `APD_WAKE_CYC;

    logic          any_edge;       // Edge on any data input
    logic          awake_prev_r;   // Last force-awake sample
    logic          idle_done_r;    // 30 s timer expired
    logic [31:0]   idle_cnt_r;     // Inactivity counter
    logic [31:0]   inv_cnt_r;      // Invalid-level counter
    logic [31:0]   val_cnt_r;      // Valid-level delay counter
    logic [10:0]   wake_cnt_r;     // Cycles since wake began
    logic [11:0]   wake_wait_r;    // Cycles up but not yet ready
    logic [31:0]   valid_run_r;    // Consecutive valid-level cycles
    logic [31:0]   inv_run_r;      // Consecutive invalid-level cycles
    logic          down;           // Combined power-down request
    logic          awake_fall;     // Force-awake falling edge
    logic          any_valid;      // Some receiver sees valid level
    apd_pkg::pwr_state_t state_r;  // Power state

    // [RQ19] edges on synced inputs
    apd_edge_det #(
        .WIDTH (NE)
    ) u_edge (
        .clk      (clk),
        .reset    (reset),
        .sig      ({tx_in, rx_in}),
        .any_edge (any_edge)
    );

    // Remember force-awake for its falling edge
    always_ff @(posedge clk) begin
        if (reset) begin
            awake_prev_r <= 1'b0;
        end else begin
            awake_prev_r <= force_awake_input;
        end
    end

    always_comb begin
        awake_fall = awake_prev_r & ~force_awake_input;
        any_valid  = |rx_level_valid;
    end

    // [RQ18] inactivity counter
    // [RQ6] held expired while down; edge or awake rise clears
    // [RQ8] awake fall restarts full 30 s
    always_ff @(posedge clk) begin
        if (reset) begin
            idle_cnt_r  <= 32'h0000_0000;
            idle_done_r <= 1'b0;
        end else if (any_edge || force_awake_input || awake_fall) begin
            // Activity, or forced on: restart the count
            idle_cnt_r  <= 32'h0000_0000;
            idle_done_r <= 1'b0;
        end else if (!force_sleep_input) begin
            // [RQ6] manual powerdown sets timer expired
            idle_done_r <= 1'b1;
        end else if (!idle_done_r) begin
            // [RQ4] count inactivity toward shutdown
            if (idle_cnt_r >= 32'(IDLE_CYC - 1)) begin
                idle_done_r <= 1'b1;
            end else begin
                idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
            end
        end
    end

    // [RQ1] sleep low wins; [RQ2] [RQ3] auto only when awake low
    // [RQ5] [RQ7] edge or both high clears done
    // [RQ16] stays down until edge after valid return
    // An edge wakes at once, not a cycle after the timer clears
    always_comb begin
        down = !force_sleep_input ||
               (!force_awake_input && idle_done_r && !any_edge);
    end

    // Power state: down, charging, active
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r    <= apd_pkg::PWR_ACTIVE;
            wake_cnt_r <= 11'h000;
        end else if (down) begin
            state_r    <= apd_pkg::PWR_DOWN;
            wake_cnt_r <= 11'h000;
        end else begin
            case (state_r)
                apd_pkg::PWR_DOWN: begin
                    state_r    <= apd_pkg::PWR_WAKING;
                    wake_cnt_r <= 11'h000;
                end
                apd_pkg::PWR_WAKING: begin
                    // [RQ9] [RQ14] ready at pump or 100 us bound
                    // Counter wide enough for the full 100 us
                    if (pump_ok || wake_cnt_r >= 11'(WK - 2)) begin
                        state_r <= apd_pkg::PWR_ACTIVE;
                    end else begin
                        wake_cnt_r <= wake_cnt_r + 11'h001;
                    end
                end
                apd_pkg::PWR_ACTIVE: begin
                    state_r <= apd_pkg::PWR_ACTIVE;
                end
                default: begin
                    state_r <= apd_pkg::PWR_DOWN;
                end
            endcase
        end
    end

    // Output enables, all registered
    always_ff @(posedge clk) begin
        if (reset) begin
            pump_en   <= 1'b1;
            tx_en     <= 1'b1;
            rx_out_en <= 1'b1;
            ready     <= 1'b1;
        end else begin
            // [RQ4] pump and transmitters off when down
            pump_en   <= !down;
            // Transmitters wait for the pump rail
            tx_en     <= !down && state_r != apd_pkg::PWR_DOWN &&
                         (pump_ok || state_r == apd_pkg::PWR_ACTIVE);
            // [RQ10] monitor variant drops receivers in powerdown
            rx_out_en <= HAS_MONITOR ? !down : 1'b1;
            // [RQ14] ready low down, high at pump threshold
            ready     <= !down && state_r != apd_pkg::PWR_DOWN &&
                         (pump_ok || state_r == apd_pkg::PWR_ACTIVE);
        end
    end

    // [RQ11] [RQ12] [RQ13] level flag timers, any mode
    always_ff @(posedge clk) begin
        if (reset) begin
            inv_cnt_r          <= 32'h0000_0000;
            val_cnt_r          <= 32'h0000_0000;
            level_valid_n_flag <= 1'b0;
        end else if (any_valid) begin
            inv_cnt_r <= 32'h0000_0000;
            // [RQ12] rise after 1 us of valid level
            if (val_cnt_r >= 32'(VALID_CYC - 1)) begin
                level_valid_n_flag <= 1'b1;
            end else begin
                val_cnt_r <= val_cnt_r + 32'h0000_0001;
            end
        end else begin
            val_cnt_r <= 32'h0000_0000;
            // [RQ11] fall after more than 30 us invalid
            if (inv_cnt_r >= 32'(INVALID_CYC - 1)) begin
                level_valid_n_flag <= 1'b0;
            end else begin
                inv_cnt_r <= inv_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Checker helpers: run lengths counted apart from the flag
    // timers, so the flag checks do not just echo the design
    // [RQ12] valid-level run
    always_ff @(posedge clk) begin
        if (reset || !any_valid) begin
            valid_run_r <= 32'h0000_0000;
        end else if (valid_run_r < 32'(VALID_CYC)) begin
            valid_run_r <= valid_run_r + 32'h0000_0001;
        end
    end

    // [RQ11] invalid-level run
    always_ff @(posedge clk) begin
        if (reset || any_valid) begin
            inv_run_r <= 32'h0000_0000;
        end else if (inv_run_r < 32'(INVALID_CYC)) begin
            inv_run_r <= inv_run_r + 32'h0000_0001;
        end
    end

    // [RQ9] cycles up but not ready; saturates, never wraps
    always_ff @(posedge clk) begin
        if (reset || down || ready) begin
            wake_wait_r <= 12'h000;
        end else if (wake_wait_r != 12'hFFF) begin
            wake_wait_r <= wake_wait_r + 12'h001;
        end
    end

    // Assertions
    property p_sleep_wins;
        @(posedge clk) disable iff (reset)
        !force_sleep_input |=> !pump_en && !ready;
    endproperty
    a_sleep_wins: assert property (p_sleep_wins) // [RQ1]
        else $error("sleep low did not power down");

    property p_awake_on;
        @(posedge clk) disable iff (reset)
        force_awake_input && force_sleep_input |=> pump_en;
    endproperty
    a_awake_on: assert property (p_awake_on) // [RQ2]
        else $error("forced awake but pump off");

    property p_auto_gate;
        @(posedge clk) disable iff (reset)
        force_awake_input |=> !idle_done_r;
    endproperty
    a_auto_gate: assert property (p_auto_gate) // [RQ3]
        else $error("idle timer expired while forced awake");

    property p_auto_off;
        @(posedge clk) disable iff (reset)
        idle_done_r && force_sleep_input && !force_awake_input
            && !any_edge |=> !pump_en && !tx_en;
    endproperty
    a_auto_off: assert property (p_auto_off) // [RQ4]
        else $error("pump on after idle timeout");

    property p_edge_wake;
        @(posedge clk) disable iff (reset)
        force_sleep_input && any_edge |=> pump_en;
    endproperty
    a_edge_wake: assert property (p_edge_wake) // [RQ5]
        else $error("edge did not wake");

    property p_timer_held;
        @(posedge clk) disable iff (reset)
        idle_done_r && force_sleep_input && !force_awake_input
            && !any_edge && !awake_fall |=> idle_done_r;
    endproperty
    a_timer_held: assert property (p_timer_held) // [RQ6]
        else $error("expired timer cleared without cause");

    // Sleep released with awake low and no activity
    sequence s_sleep_release;
        (!force_sleep_input && !force_awake_input && !any_edge
            && !awake_fall) ##1
        (force_sleep_input && !force_awake_input && !any_edge);
    endsequence
    property p_manual_hold;
        @(posedge clk) disable iff (reset)
        s_sleep_release |=> !pump_en;
    endproperty
    a_manual_hold: assert property (p_manual_hold) // [RQ7]
        else $error("left manual powerdown without cause");

    property p_awake_fall;
        @(posedge clk) disable iff (reset)
        awake_fall |=> !idle_done_r && idle_cnt_r == 32'h0000_0000;
    endproperty
    a_awake_fall: assert property (p_awake_fall) // [RQ8]
        else $error("awake fall did not restart timer");

    // Worst case: wake seen, WK cycles, ready lands one later
    property p_wake_bound;
        @(posedge clk) disable iff (reset)
        wake_wait_r <= 12'(WK + 1);
    endproperty
    a_wake_bound: assert property (p_wake_bound) // [RQ9]
        else $error("ready not reached within bound");

    property p_monitor_rx;
        @(posedge clk) disable iff (reset)
        down |=> rx_out_en == !HAS_MONITOR;
    endproperty
    a_monitor_rx: assert property (p_monitor_rx) // [RQ10]
        else $error("receiver enable wrong in powerdown");

    property p_invalid_hold;
        @(posedge clk) disable iff (reset)
        $rose(level_valid_n_flag) |-> $past(any_valid);
    endproperty
    a_invalid_hold: assert property (p_invalid_hold) // [RQ11]
        else $error("flag rose without valid level");

    property p_invalid_fall;
        @(posedge clk) disable iff (reset)
        inv_run_r == 32'(INVALID_CYC) |-> !level_valid_n_flag;
    endproperty
    a_invalid_fall: assert property (p_invalid_fall) // [RQ11]
        else $error("flag high after long invalid level");

    property p_invalid_delay;
        @(posedge clk) disable iff (reset)
        $fell(level_valid_n_flag) |-> inv_run_r == 32'(INVALID_CYC);
    endproperty
    a_invalid_delay: assert property (p_invalid_delay) // [RQ11]
        else $error("flag fell at wrong time");

    property p_valid_rise;
        @(posedge clk) disable iff (reset)
        valid_run_r == 32'(VALID_CYC) |-> level_valid_n_flag;
    endproperty
    a_valid_rise: assert property (p_valid_rise) // [RQ12]
        else $error("flag not high after valid level");

    property p_valid_delay;
        @(posedge clk) disable iff (reset)
        $rose(level_valid_n_flag) |-> valid_run_r == 32'(VALID_CYC);
    endproperty
    a_valid_delay: assert property (p_valid_delay) // [RQ12]
        else $error("flag rose at wrong time");

    property p_ready_low;
        @(posedge clk) disable iff (reset)
        down |=> !ready && !tx_en;
    endproperty
    a_ready_low: assert property (p_ready_low) // [RQ14]
        else $error("ready high in powerdown");
endmodule // auto_powerdown_control

//--- verif/apd_host_model.sv
// Power-management logic driving the force pins
module apd_host_model (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    input  wire logic       shut_n,
    input  wire logic       awake_req,
    input  wire logic       flag,
    output logic            awake,
    output logic            sleep
);
    timeunit 1ns;
    timeprecision 1ns;
    // Mode 0 direct, 1 tied, 2 flag on both, 3 flag on sleep
    // strapping schemes
    assign awake = (mode == 2'h0) ? awake_req :
                   (mode == 2'h1) ? shut_n :
                   (mode == 2'h2) ? flag : 1'b0;
    assign sleep = (mode == 2'h0) ? shut_n :
                   (mode == 2'h1) ? shut_n : flag;
endmodule // apd_host_model

//--- verif/auto_powerdown_control_tb.sv
// Bench for the powerdown controller
module auto_powerdown_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, reset, shut_n, awake_req, pump_ok;
    logic [1:0] mode, tx_in, rx_in, rx_level_valid;
    logic       fa, fs, pump_en, tx_en, rx_out_en, ready, flag;
    int         n_errors, samples_checked, k, exp_up;

    apd_host_model host (.clk(clk), .mode(mode), .shut_n(shut_n),
        .awake_req(awake_req), .flag(flag), .awake(fa), .sleep(fs));

    auto_powerdown_control #(.HAS_MONITOR(1'b1), .IDLE_CYC(50)) dut (
        .clk(clk), .reset(reset), .force_awake_input(fa),
        .force_sleep_input(fs), .tx_in(tx_in), .rx_in(rx_in),
        .rx_level_valid(rx_level_valid), .pump_ok(pump_ok),
        .pump_en(pump_en), .tx_en(tx_en), .rx_out_en(rx_out_en),
        .ready(ready), .level_valid_n_flag(flag));

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pump rail settles one cycle after enable
    always @(posedge clk) pump_ok <= pump_en;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic chk(input string nm, input logic s, input logic e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %b got %b", nm, e, s);
        end
    endtask

    // Model power state against all power outputs
    // exp_up bit 0: pump on; bit 1: rail up, ready to transmit
    task automatic chk_pwr();
        chk("pump_en", pump_en, exp_up[0]);
        chk("tx_en", tx_en, exp_up[1]);
        chk("rx_out_en", rx_out_en, exp_up[0]);
        chk("ready", ready, exp_up[1]);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bounded wait, 2000 cycles is the wake limit
    task automatic wait_ready();
        k = 0;
        while (ready !== 1'b1 && k < 2000) begin
            step(1);
            k++;
        end
        chk("ready", ready, 1'b1);
        if (ready !== 1'b1)
            wrap_up();
        exp_up = 3;
    endtask

    initial begin
        reset = 1'b1;
        mode = 2'h0;
        shut_n = 1'b1;
        awake_req = 1'b1;
        tx_in = 2'h0;
        rx_in = 2'h0;
        rx_level_valid = 2'h3;
        n_errors = 0;
        samples_checked = 0;
        k = $urandom(32'hC5F8);
        step(16);
        reset = 1'b0;
        step(30);
        exp_up = 3;
        chk_pwr();
        chk("flag", flag, 1'b1);
        // Sleep wins over awake
        shut_n = 1'b0;
        step(2);
        exp_up = 0;
        chk_pwr();
        chk("ready", ready, 1'b0);
        // Pump on first; ready only once the rail is up
        shut_n = 1'b1;
        step(2);
        exp_up = 1;
        chk_pwr();
        wait_ready();
        step(200);
        chk_pwr();
        // Awake fall restarts the idle hold
        awake_req = 1'b0;
        step(40);
        chk_pwr();
        step(20);
        exp_up = 0;
        chk_pwr();
        chk("ready", ready, 1'b0);
        // Random edge wakes
        if ($urandom % 2)
            tx_in[$urandom % 2] ^= 1'b1;
        else
            rx_in[$urandom % 2] ^= 1'b1;
        step(2);
        exp_up = 1;
        chk_pwr();
        wait_ready();
        // Manual down with awake low stays down
        shut_n = 1'b0;
        step(2);
        shut_n = 1'b1;
        step(20);
        exp_up = 0;
        chk_pwr();
        awake_req = 1'b1;
        step(2);
        exp_up = 1;
        chk_pwr();
        wait_ready();
        // Flag timing, no effect on power
        rx_level_valid = 2'h0;
        step(590);
        chk("flag", flag, 1'b1);
        step(20);
        chk("flag", flag, 1'b0);
        chk_pwr();
        rx_level_valid[$urandom % 2] = 1'b1;
        step(10);
        chk("flag", flag, 1'b0);
        step(15);
        chk("flag", flag, 1'b1);
        // Flag on both pins
        mode = 2'h2;
        rx_level_valid = 2'h0;
        step(620);
        exp_up = 0;
        chk_pwr();
        rx_level_valid = 2'h1;
        step(30);
        exp_up = 3;
        chk_pwr();
        wait_ready();
        // Hybrid needs valid level plus an edge
        mode = 2'h3;
        rx_level_valid = 2'h0;
        step(620);
        exp_up = 0;
        chk_pwr();
        rx_level_valid = 2'h3;
        step(40);
        chk_pwr();
        rx_in[0] ^= 1'b1;
        step(2);
        exp_up = 1;
        chk_pwr();
        // Pins tied as one shutdown input
        mode = 2'h1;
        shut_n = 1'b0;
        step(2);
        exp_up = 0;
        chk_pwr();
        shut_n = 1'b1;
        step(100);
        exp_up = 3;
        chk_pwr();
        wrap_up();
    end
endmodule // auto_powerdown_control_tb
